// File: rtl/io_expander_port_regs.sv
// register file, interrupt capture and pin drive of the 8-bit port expander
// Functional notes
// - sequential_disable at bit 5 holds the pointer; clear advances it each byte
// - irq_open_drain_select at bit 2 makes the irq pin open drain, level ignored
// - irq_active_level at bit 1: 1 active high, 0 active low, push-pull only
// - irq_clear_select at bit 0: 1 capture read clears, 0 port read clears
// - a clearing read takes effect only once the interrupt condition is gone
// - config bits 7, 6, 4 and 3 always read as zero
// - each set pullup_bits bit enables the pin pull-up, input or output
// - irq_flags mark pins that caused the interrupt, only for enabled pins
// - irq_flags is read only, writes are ignored
// - irq_capture loads the port value at the interrupt and holds until cleared
// - a port read returns the pin levels, not the latch
// - a port write goes into the output latch
// - an output latch read returns the stored latch
// - latch writes update the latch and drive pins set as outputs
// - direction 1 is input, 0 is output; all reset to input
// - an input_invert bit inverts the port read of that pin
// - only input pins with change interrupt enabled can raise the interrupt
// - clear after the read lsb leaves the link; writes never arm the clear
`timescale 1ns/1ps
`include "io_expander_cfg.svh"

module io_expander_port_regs (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// byte register port from the serial engine
	input wire io_expander_pkg::regReq_t req,
	output logic [7:0] rdData,
	output logic rdValid,
	// port pins, open drain
	input wire logic [7:0] pinIn,
	output logic [7:0] pinOut,
	output logic [7:0] pinOeN,
	output logic [7:0] pullupEn,
	// interrupt pin
	output logic irqOut,
	output logic irqOeN
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [7:0] pinDirection_reg, inputInvert_reg, changeIrqEnable_reg, defaultCompare_reg;
	logic [7:0] compareSource_reg, expanderConfig_reg, pullupEnable_reg, irqFlags_reg;
	logic [7:0] irqCapture_reg, outputLatch_reg, prevValue_reg, pointer_reg;
	logic irqPending_reg, levelCond, clearRead, clearNow, setNow, wrEn, rdEn;
	io_expander_pkg::clrState_t clrState_reg, clrState_next;
	logic [7:0] pinSync, portValue, eligible, condBits;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// next pointer value after one byte
	function automatic logic [7:0] stepPointer(input logic [7:0] ptr, input logic hold);
		if (hold) begin
			return ptr;
		end else if (ptr == `OFS_LAST) begin
			return 8'h00;
		end else begin
			return ptr + 8'h01;
		end
	endfunction : stepPointer

	// read data of one register
	function automatic logic [7:0] regRead(input logic [7:0] a);
		case (a)
			`OFS_PIN_DIRECTION: return pinDirection_reg;
			`OFS_INPUT_INVERT: return inputInvert_reg;
			`OFS_CHANGE_IRQ_ENABLE: return changeIrqEnable_reg;
			`OFS_DEFAULT_COMPARE: return defaultCompare_reg;
			`OFS_COMPARE_SOURCE: return compareSource_reg;
			`OFS_EXPANDER_CONFIG: return expanderConfig_reg & `CFG_IMPL_MASK;
			`OFS_PULLUP_ENABLE: return pullupEnable_reg;
			`OFS_IRQ_FLAGS: return irqFlags_reg;
			`OFS_IRQ_CAPTURE: return irqCapture_reg;
			`OFS_PORT_VALUE: return portValue;
			`OFS_OUTPUT_LATCH: return outputLatch_reg;
			default: return 8'h00;
		endcase
	endfunction : regRead

	// ----------------------------------------------------------------
	// pin sampling and interrupt conditions
	// ----------------------------------------------------------------
	io_pin_sync u_pinSync (
		.clk(clk),
		.resetn(resetn),
		.asyncIn(pinIn),
		.syncOut(pinSync)
	);

	// port value with per-pin inversion
	assign portValue = pinSync ^ inputInvert_reg;
	assign eligible = changeIrqEnable_reg & pinDirection_reg;
	assign condBits = eligible & (compareSource_reg & (portValue ^ defaultCompare_reg)
		| ~compareSource_reg & (portValue ^ prevValue_reg));
	assign levelCond = |(eligible & compareSource_reg & (portValue ^ defaultCompare_reg));

	// byte strobes, a transfer start takes precedence
	assign wrEn = req.wrStrobe && !req.xferStart;
	assign rdEn = req.rdStrobe && !req.xferStart;
	assign clearRead = rdEn && (pointer_reg == (expanderConfig_reg[`CFG_IRQ_CLEAR_SELECT]
		? `OFS_IRQ_CAPTURE : `OFS_PORT_VALUE));
	assign clearNow = (clrState_reg != io_expander_pkg::CLR_IDLE) && !levelCond
		&& (clrState_reg == io_expander_pkg::CLR_WAIT || req.lsbDone);
	assign setNow = (|condBits) && (!irqPending_reg || clearNow);

	// ----------------------------------------------------------------
	// address pointer
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pointer_reg <= 8'h00;
		end else if (req.xferStart) begin
			pointer_reg <= req.addr;
		end else if (wrEn || rdEn) begin
			pointer_reg <= stepPointer(pointer_reg,
				expanderConfig_reg[`CFG_SEQUENTIAL_DISABLE]);
		end
	end

	// ----------------------------------------------------------------
	// writable registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pinDirection_reg <= `RST_PIN_DIRECTION;
			inputInvert_reg <= `RST_ZERO;
			changeIrqEnable_reg <= `RST_ZERO;
			defaultCompare_reg <= `RST_ZERO;
			compareSource_reg <= `RST_ZERO;
			expanderConfig_reg <= `RST_ZERO;
			pullupEnable_reg <= `RST_ZERO;
			outputLatch_reg <= `RST_ZERO;
		end else if (wrEn) begin
			case (pointer_reg)
				`OFS_PIN_DIRECTION: pinDirection_reg <= req.wrData;
				`OFS_INPUT_INVERT: inputInvert_reg <= req.wrData;
				`OFS_CHANGE_IRQ_ENABLE: changeIrqEnable_reg <= req.wrData;
				`OFS_DEFAULT_COMPARE: defaultCompare_reg <= req.wrData;
				`OFS_COMPARE_SOURCE: compareSource_reg <= req.wrData;
				`OFS_EXPANDER_CONFIG: expanderConfig_reg <= req.wrData & `CFG_IMPL_MASK;
				`OFS_PULLUP_ENABLE: pullupEnable_reg <= req.wrData;
				`OFS_PORT_VALUE: outputLatch_reg <= req.wrData;
				`OFS_OUTPUT_LATCH: outputLatch_reg <= req.wrData;
				default: ; // flags and capture ignore writes
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdData <= 8'h00;
			rdValid <= 1'b0;
		end else begin
			rdValid <= rdEn;
			if (rdEn) begin
				rdData <= regRead(pointer_reg);
			end
		end
	end

	// ----------------------------------------------------------------
	// clear sequencer: armed by the selected read, fires after the lsb
	// ----------------------------------------------------------------
	always_comb begin
		clrState_next = clrState_reg;
		case (clrState_reg)
			io_expander_pkg::CLR_IDLE: begin
				if (clearRead && irqPending_reg) begin
					clrState_next = io_expander_pkg::CLR_ARMED;
				end
			end
			io_expander_pkg::CLR_ARMED: begin
				if (req.lsbDone) begin
					clrState_next = levelCond ? io_expander_pkg::CLR_WAIT
						: io_expander_pkg::CLR_IDLE;
				end
			end
			io_expander_pkg::CLR_WAIT: begin
				if (!levelCond) begin
					clrState_next = io_expander_pkg::CLR_IDLE;
				end
			end
			default: clrState_next = io_expander_pkg::CLR_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			clrState_reg <= io_expander_pkg::CLR_IDLE;
		end else begin
			clrState_reg <= clrState_next;
		end
	end

	// ----------------------------------------------------------------
	// interrupt flags, capture and reference value
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irqPending_reg <= 1'b0;
			irqFlags_reg <= `RST_ZERO;
		end else if (setNow) begin
			irqPending_reg <= 1'b1; // new event wins over a clear
			irqFlags_reg <= condBits;
		end else if (clearNow) begin
			irqPending_reg <= 1'b0;
			irqFlags_reg <= `RST_ZERO;
		end
	end

	// capture has no defined reset value
	always_ff @(posedge clk) begin
		if (setNow) begin
			irqCapture_reg <= portValue;
		end
	end

	// reference tracks the port while idle, freezes while pending
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prevValue_reg <= `RST_ZERO;
		end else if (!irqPending_reg || setNow) begin
			prevValue_reg <= portValue;
		end
	end

	// ----------------------------------------------------------------
	// pin and interrupt drive
	// ----------------------------------------------------------------
	assign pinOut = 8'h00; // open drain only ever sinks

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pinOeN <= 8'hFF;
			pullupEn <= `RST_ZERO;
			irqOut <= 1'b1;
			irqOeN <= 1'b1;
		end else begin
			pinOeN <= pinDirection_reg | outputLatch_reg;
			pullupEn <= pullupEnable_reg;
			if (expanderConfig_reg[`CFG_IRQ_OPEN_DRAIN_SELECT]) begin
				irqOut <= 1'b0;
				irqOeN <= !irqPending_reg;
			end else begin
				irqOut <= irqPending_reg ~^ expanderConfig_reg[`CFG_IRQ_ACTIVE_LEVEL];
				irqOeN <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_seqHold;
		(wrEn || rdEn) && expanderConfig_reg[`CFG_SEQUENTIAL_DISABLE]
			|=> $stable(pointer_reg);
	endproperty
	a_seqHold: assert property (p_seqHold) else $error("pointer moved while held");

	property p_seqStep;
		(wrEn || rdEn) && !expanderConfig_reg[`CFG_SEQUENTIAL_DISABLE]
			&& pointer_reg < `OFS_LAST |=> pointer_reg == $past(pointer_reg) + 8'h01;
	endproperty
	a_seqStep: assert property (p_seqStep) else $error("pointer did not advance");

	property p_odDrive;
		##1 $past(expanderConfig_reg[`CFG_IRQ_OPEN_DRAIN_SELECT])
			|-> !irqOut && (irqOeN == !$past(irqPending_reg));
	endproperty
	a_odDrive: assert property (p_odDrive) else $error("open drain irq drive wrong");

	property p_ppLevel;
		##1 !$past(expanderConfig_reg[`CFG_IRQ_OPEN_DRAIN_SELECT]) |-> !irqOeN
			&& irqOut == ($past(irqPending_reg) == $past(expanderConfig_reg[1]));
	endproperty
	a_ppLevel: assert property (p_ppLevel) else $error("push-pull irq level wrong");

	property p_noClearOnCond;
		irqPending_reg && levelCond && !setNow |=> irqPending_reg;
	endproperty
	a_noClearOnCond: assert property (p_noClearOnCond) else $error("cleared with live cond");

	property p_cfgZero;
		rdEn && pointer_reg == `OFS_EXPANDER_CONFIG |=> (rdData & ~`CFG_IMPL_MASK) == 8'h00;
	endproperty
	a_cfgZero: assert property (p_cfgZero) else $error("unimplemented config bit set");

	property p_flagsRo;
		wrEn && pointer_reg == `OFS_IRQ_FLAGS && !setNow && !clearNow |=> $stable(irqFlags_reg);
	endproperty
	a_flagsRo: assert property (p_flagsRo) else $error("flag write took effect");

	property p_captureHold;
		irqPending_reg && !clearNow |=> $stable(irqCapture_reg);
	endproperty
	a_captureHold: assert property (p_captureHold) else $error("capture changed");

	property p_portRead;
		rdEn && pointer_reg == `OFS_PORT_VALUE |=> rdData == $past(pinSync ^ inputInvert_reg);
	endproperty
	a_portRead: assert property (p_portRead) else $error("port read not pin level");

	property p_portWrite;
		wrEn && pointer_reg == `OFS_PORT_VALUE |=> outputLatch_reg == $past(req.wrData)
			##1 pinOeN == $past(pinDirection_reg | outputLatch_reg);
	endproperty
	a_portWrite: assert property (p_portWrite) else $error("port write missed latch");

	property p_onlyInputs;
		setNow |=> (irqFlags_reg & ~$past(eligible)) == 8'h00;
	endproperty
	a_onlyInputs: assert property (p_onlyInputs) else $error("flag on ineligible pin");

	property p_clearAfterLsb;
		clrState_reg == io_expander_pkg::CLR_ARMED && !req.lsbDone && !setNow
			|=> irqPending_reg;
	endproperty
	a_clearAfterLsb: assert property (p_clearAfterLsb) else $error("cleared before lsb");

	c_irqSet: cover property (!irqPending_reg ##1 irqPending_reg);
	c_clearDone: cover property (clrState_reg == io_expander_pkg::CLR_ARMED ##1 !irqPending_reg);
	c_clearWait: cover property (clrState_reg == io_expander_pkg::CLR_WAIT);
	c_seqHeld: cover property (rdEn && expanderConfig_reg[`CFG_SEQUENTIAL_DISABLE]);

endmodule : io_expander_port_regs

// File: rtl/io_pin_sync.sv
// two flip-flop synchroniser for the port pin inputs
`timescale 1ns/1ps
`include "io_expander_cfg.svh"

module io_pin_sync (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// asynchronous levels in, synchronised levels out
	input wire logic [`PORT_WIDTH-1:0] asyncIn,
	output logic [`PORT_WIDTH-1:0] syncOut
);

	logic [`PORT_WIDTH-1:0] stage1_reg;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stage1_reg <= `RST_ZERO;
			syncOut <= `RST_ZERO;
		end else begin
			stage1_reg <= asyncIn;
			syncOut <= stage1_reg;
		end
	end

endmodule : io_pin_sync

// File: shared/io_expander_cfg.svh
// register offsets, field positions and reset values of the port expander
`ifndef IO_EXPANDER_CFG_SVH
`define IO_EXPANDER_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_PIN_DIRECTION 8'h00
`define OFS_INPUT_INVERT 8'h01
`define OFS_CHANGE_IRQ_ENABLE 8'h02
`define OFS_DEFAULT_COMPARE 8'h03
`define OFS_COMPARE_SOURCE 8'h04
`define OFS_EXPANDER_CONFIG 8'h05
`define OFS_PULLUP_ENABLE 8'h06
`define OFS_IRQ_FLAGS 8'h07
`define OFS_IRQ_CAPTURE 8'h08
`define OFS_PORT_VALUE 8'h09
`define OFS_OUTPUT_LATCH 8'h0A
`define OFS_LAST 8'h0A

// ----------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------
`define CFG_SEQUENTIAL_DISABLE 5
`define CFG_IRQ_OPEN_DRAIN_SELECT 2
`define CFG_IRQ_ACTIVE_LEVEL 1
`define CFG_IRQ_CLEAR_SELECT 0
`define CFG_IMPL_MASK 8'h27

// ----------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------
`define PORT_WIDTH 8
`define RST_PIN_DIRECTION 8'hFF
`define RST_ZERO 8'h00

`endif

// File: shared/io_expander_pkg.sv
// types shared by the port expander register block
package io_expander_pkg;

	// byte-level register access from the serial engine
	typedef struct packed {
		logic xferStart;   // new transfer, pointer loads from addr
		logic [7:0] addr;  // register address byte
		logic wrStrobe;    // one data byte written at pointer
		logic [7:0] wrData;
		logic rdStrobe;    // one data byte fetched at pointer
		logic lsbDone;     // last bit of the fetched byte has left the link
	} regReq_t;

	// interrupt clear sequencer, gray coded along the usual path
	typedef enum logic [1:0] {
		CLR_IDLE = 2'b00,
		CLR_ARMED = 2'b01,
		CLR_WAIT = 2'b11
	} clrState_t;

endpackage : io_expander_pkg

// File: sim/pin_world.sv
// pin world model: open-drain port pins facing external drivers
`timescale 1ns/1ps

module pin_world (
	// design drive
	input wire logic [7:0] pinOut,
	input wire logic [7:0] pinOeN,
	// external circuitry
	input wire logic [7:0] extDrive,
	// resolved levels
	output logic [7:0] pinLvl
);
	// ----------------------------------------------------------------
	// wire resolution
	// ----------------------------------------------------------------
	// a driven pin sinks to pinOut, a released one shows the external level
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pinLvl[i] = pinOeN[i] ? extDrive[i] : pinOut[i];
		end
	end
endmodule : pin_world

// File: sim/tb_io_expander_port_regs.sv
// self-checking bench of the port expander register block
`timescale 1ns/1ps

module tb_io_expander_port_regs;
	// ----------------------------------------------------------------
	// signals and model state
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic resetn = 1'b0;
	io_expander_pkg::regReq_t req = '0;
	logic [7:0] rdData, pinOut, pinOeN, pullupEn, pinLvl;
	logic rdValid, irqOut, irqOeN;
	logic [7:0] extDrive = 8'h00;
	int err_count = 0;
	int n_tests = 0;
	int cycles = 0;
	int ptr = 0;
	int seed = 32'h3d521056;
	logic [7:0] m [0:10];
	logic [7:0] flg, cap, c;
	logic capKnown = 1'b0;
	logic [7:0] cfgs [5] = '{8'h00, 8'h01, 8'h04, 8'h02, 8'h06};

	always #12.5 clk = ~clk;

	io_expander_port_regs i_dut (.clk(clk), .resetn(resetn), .req(req), .rdData(rdData),
		.rdValid(rdValid), .pinIn(pinLvl), .pinOut(pinOut), .pinOeN(pinOeN),
		.pullupEn(pullupEn), .irqOut(irqOut), .irqOeN(irqOeN));
	pin_world i_pins (.pinOut(pinOut), .pinOeN(pinOeN), .extDrive(extDrive), .pinLvl(pinLvl));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk);
		#2;
	endtask : tick

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk

	task automatic wrap_up();
		$display("mismatches %0d comparisons %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up

	// every request cycle assigns all strobes once, then lets one edge pass
	task automatic drive(input logic x, input logic w, input logic r, input logic l);
		req.xferStart = x;
		req.wrStrobe = w;
		req.rdStrobe = r;
		req.lsbDone = l;
		tick();
	endtask : drive

	// expected pin level: a pin sinks only when output with latch 0
	function automatic logic [7:0] lvl();
		return (m[0] | m[10]) & extDrive;
	endfunction : lvl

	task automatic step();
		if (!m[5][5]) ptr = (ptr == 10) ? 0 : ptr + 1;
	endtask : step

	task automatic xfer(input int a);
		req.addr = 8'(a);
		ptr = a;
		drive(1'b1, 1'b0, 1'b0, 1'b0);
	endtask : xfer

	task automatic wrB(input logic [7:0] d);
		int a;
		a = ptr;
		req.wrData = d;
		drive(1'b0, 1'b1, 1'b0, 1'b0);
		step(); // pointer steps on the config in force before the byte
		if (a == 5) m[5] = d & 8'h27;
		else if (a == 9) m[10] = d;
		else if (a != 7 && a != 8) m[a] = d;
	endtask : wrB

	task automatic rdB();
		logic [7:0] e;
		e = (ptr == 7) ? flg : (ptr == 8) ? cap : (ptr == 9) ? (lvl() ^ m[1]) : m[ptr];
		drive(1'b0, 1'b0, 1'b1, 1'b0);
		chk({7'h00, rdValid}, 8'h01, "read valid");
		if (ptr != 8 || capKnown) chk(rdData, e, "read data");
		step();
	endtask : rdB

	task automatic wr1(input int a, input logic [7:0] d);
		xfer(a);
		wrB(d);
		drive(1'b0, 1'b0, 1'b0, 1'b0);
	endtask : wr1

	// read one byte, then report its last bit gone from the link
	task automatic rdClr(input int a);
		xfer(a);
		rdB();
		drive(1'b0, 1'b0, 1'b0, 1'b0);
		drive(1'b0, 1'b0, 1'b0, 1'b1);
		drive(1'b0, 1'b0, 1'b0, 1'b0);
		tick(2);
	endtask : rdClr

	task automatic irqChk(input logic pend);
		chk({6'h00, irqOeN, irqOut & ~c[2]}, {6'h00, c[2] & ~pend, ~c[2] & (c[1] ^ ~pend)},
			"irq pin");
	endtask : irqChk

	// ----------------------------------------------------------------
	// hang guard
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			$display("CHECK FAILED t=%0t run too long", $time);
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		for (int i = 0; i < 11; i++) m[i] = (i == 0) ? 8'hFF : 8'h00;
		flg = 8'h00;
		cap = 8'h00;
		c = 8'h00;
		tick(2);
		resetn = 1'b1;
		chk(pinOeN, 8'hFF, "direction reset");
		chk(pullupEn, 8'h00, "pull-up reset");
		// burst read of every register, wrapping back to the start
		xfer(0);
		for (int i = 0; i < 12; i++) rdB();
		// config write with all bits, held pointer, then stepping again
		xfer(5);
		wrB(8'hFF);
		for (int i = 0; i < 3; i++) rdB();
		xfer(5);
		wrB(8'hDA);
		rdB();
		wrB(8'($random(seed)));
		wrB(8'hFF);
		wrB(8'h5A);
		drive(1'b0, 1'b0, 1'b0, 1'b0);
		chk(pullupEn, m[6], "pull-up copy");
		xfer(5);
		for (int i = 0; i < 4; i++) rdB();
		// random direction, invert, pins and latch through both latch paths
		for (int k = 0; k < 6; k++) begin
			wr1(0, 8'($random(seed)));
			wr1(1, 8'($random(seed)));
			extDrive = 8'($random(seed));
			wr1((k % 2) ? 9 : 10, 8'($random(seed)));
			tick(4);
			chk(pinOeN, m[0] | m[10], "pin drive");
			xfer(9);
			rdB();
			rdB();
			drive(1'b0, 1'b0, 1'b0, 1'b0);
		end
		// pin-change interrupt on pin 0 in every pin and clear mode
		extDrive = 8'h00;
		wr1(0, 8'hFF);
		wr1(1, 8'h00);
		wr1(2, 8'h01);
		tick(4);
		foreach (cfgs[j]) begin
			c = cfgs[j];
			wr1(5, c);
			tick(2);
			irqChk(1'b0);
			extDrive[0] = ~extDrive[0];
			tick(6);
			flg = 8'h01;
			cap = lvl() ^ m[1];
			capKnown = 1'b1;
			irqChk(1'b1);
			wr1(7, 8'hFE);
			wr1(8, 8'h5A);
			wr1(9, m[10]);
			irqChk(1'b1);
			rdClr(7);
			rdClr(c[0] ? 9 : 8);
			irqChk(1'b1);
			rdClr(c[0] ? 8 : 9);
			irqChk(1'b0);
		end
		// default compare mismatch keeps the interrupt through a clearing read
		c = 8'h00;
		wr1(5, c);
		wr1(3, 8'h00);
		wr1(4, 8'h01);
		tick(6);
		irqChk(1'b1);
		rdClr(9);
		irqChk(1'b1);
		extDrive[0] = 1'b0;
		tick(8);
		irqChk(1'b0);
		// an output pin that toggles never raises the interrupt
		wr1(4, 8'h00);
		wr1(10, m[10] | 8'h01);
		wr1(0, 8'hFE);
		extDrive[0] = 1'b1;
		tick(8);
		irqChk(1'b0);
		wrap_up();
	end
endmodule : tb_io_expander_port_regs
